// *** logic/xts_pkg.sv ***
// package: register map, field layouts, encodings and timing for the crystal trim sequencer
package xts_pkg;

    // clock and timing
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned RAMP_TIMEOUT_NS = 32000;
    localparam int unsigned RAMP_TIMEOUT_CYCLES = RAMP_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int TIMER_W = 9;
    localparam logic [TIMER_W-1:0] RAMP_TIMEOUT_LAST = TIMER_W'(RAMP_TIMEOUT_CYCLES - 1);

    // register indices as printed; byte address is four times the index
    localparam logic [31:0] SYS_STAT_IDX = 32'h50000014;
    localparam logic [31:0] TRIM_CTRL_IDX = 32'h50000016;
    localparam logic [31:0] IRQ_STATUS_IDX = 32'h50000030;
    localparam logic [31:0] IRQ_MASK_IDX = 32'h50000031;
    localparam int IDX_DEC_W = 10;

    // widths
    localparam int TRIM_W = 8;
    localparam int CNT_W = 12;
    localparam int IRQ_W = 2;
    localparam int UNIT_SHIFT = 6;

    // interrupt status / mask bit positions
    localparam int IRQ_SETTLED_BIT = 0;
    localparam int IRQ_TRIM_BIT = 1;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

    // trim control register: settle threshold, source select, delay count
    typedef struct packed {
        logic [5:0] settle_n;
        logic [1:0] trim_select;
        logic [5:0] count_n;
    } xts_ctrl_t;
    localparam int CTRL_SETTLE_LSB = 8;
    localparam int CTRL_SELECT_LSB = 6;
    localparam int CTRL_COUNT_LSB = 0;
    localparam logic [13:0] CTRL_RESET = 14'h3f22;

    // system status register layout
    typedef struct packed {
        logic crystal_settled_flag;
        logic trim_applied_flag;
        logic reserved;
        logic debugger_attached_flag;
        logic timer_domain_on_flag;
        logic timer_domain_off_flag;
        logic radio_domain_on_flag;
        logic radio_domain_off_flag;
    } xts_sys_status_t;

    // state reported by the debugger and the power domains
    typedef struct packed {
        logic debugger_attached;
        logic timer_power_domain_on;
        logic timer_power_domain_off;
        logic radio_power_domain_on;
        logic radio_power_domain_off;
    } xts_dom_status_t;

    // trim values held in the frequency trim register
    typedef struct packed {
        logic [TRIM_W-1:0] startup_trim_value;
        logic [TRIM_W-1:0] ramp_trim_value;
        logic [TRIM_W-1:0] final_trim_value;
    } xts_trim_set_t;

    // synchroniser bundle: enable, tick toggle, amplitude ramping, domain status
    localparam int SYNC_W = 8;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 8'h05;

    typedef enum logic [1:0] {
        SEL_COUNTER = 2'h0,
        SEL_AMP_FILTER = 2'h1,
        SEL_STATIC = 2'h2,
        SEL_TWO_STAGE = 2'h3
    } xts_trim_sel_t;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_START,
        ST_RAMP,
        ST_FINAL
    } xts_seq_state_t;

    // threshold fields count in units of 64 crystal cycles
    function automatic logic [CNT_W-1:0] xts_units64(input logic [5:0] n);
        xts_units64 = {n, 6'h00};
    endfunction : xts_units64

endpackage : xts_pkg

// *** logic/xts_sync.sv ***
// two-flop synchroniser bank for levels arriving from outside the pclk domain
module xts_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb begin
        next_meta = d;
        next_q = meta;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= RST;
            q <= RST;
        end else begin
            meta <= next_meta;
            q <= next_q;
        end
    end
endmodule : xts_sync

// *** logic/xts_xtal_counter.sv ***
// crystal cycle counter: counts toggles of the synchronised crystal tick, saturating
module xts_xtal_counter
    import xts_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic restart,
    input wire logic tick_toggle,
    // count
    output logic [xts_pkg::CNT_W-1:0] crystal_cycle_counter
);
    logic tick_prev;
    logic next_tick_prev;
    logic [CNT_W-1:0] next_count;

    always_comb begin
        next_tick_prev = tick_toggle;
        next_count = crystal_cycle_counter;
        if (restart) begin
            next_count = '0;
        end else if ((tick_toggle != tick_prev) && (crystal_cycle_counter != '1)) begin
            // saturate: thresholds top out at 4032, well below the wrap
            next_count = crystal_cycle_counter + CNT_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_prev <= 1'b0;
            crystal_cycle_counter <= '0;
        end else begin
            tick_prev <= next_tick_prev;
            crystal_cycle_counter <= next_count;
        end
    end
endmodule : xts_xtal_counter

// *** logic/xts_trim_seq_status.sv ***
// crystal trim sequencer and system status block with apb register access
// Summary of operation
// - settled flag sets when cycle count reaches threshold times 64; threshold resets 0x3f
// - trim-applied flag high while driven trim equals final trim; resets to one
// - read-only bit shows debugger attached to the core; zero after reset
// - timer domain on bit (reset 0) and off bit (reset 1), read-only
// - radio domain on bit (reset 0) and off bit (reset 1), read-only
// - counter mode: startup trim, then final trim after delay count; reset selection
// - amplitude mode: startup trim, final trim once amplitude detector reports ramping
// - static mode: no sequencing, final trim always driven
// - two-stage: startup, ramp trim after 32 us, final when amplitude ramps
// - delay count in units of 64 crystal cycles; resets to 0x22
//
// The APB interface to the registers was decided locally.
module xts_trim_seq_status
    import xts_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // crystal oscillator
    input wire logic xtal_enable,
    input wire logic xtal_tick_toggle,
    input wire logic xtal_amp_ramping,
    input wire xts_pkg::xts_trim_set_t trim_values,
    output logic [xts_pkg::TRIM_W-1:0] xtal_trim,
    // status sources
    input wire xts_pkg::xts_dom_status_t dom_status,
    // status out
    output logic crystal_settled,
    output logic trim_applied,
    output logic irq
);
    import xts_pkg::*;

    // synchronised inputs
    logic [SYNC_W-1:0] sync_in;
    logic [SYNC_W-1:0] sync_out;
    logic en_s;
    logic tick_s;
    logic amp_s;
    xts_dom_status_t dom_s;

    assign sync_in = {xtal_enable, xtal_tick_toggle, xtal_amp_ramping, dom_status};
    assign {en_s, tick_s, amp_s, dom_s} = sync_out;

    xts_sync #(
        .W(SYNC_W),
        .RST(SYNC_RESET)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(sync_in),
        .q(sync_out)
    );

    // enable edge and counter restart
    logic en_prev;
    logic next_en_prev;
    logic en_rise;
    logic cnt_restart;
    logic [CNT_W-1:0] cycle_count;

    // counter held clear while the oscillator is off and cleared again on every enable
    assign en_rise = en_s & ~en_prev;
    assign cnt_restart = ~en_s | en_rise;

    xts_xtal_counter u_counter (
        .pclk(pclk),
        .presetn(presetn),
        .restart(cnt_restart),
        .tick_toggle(tick_s),
        .crystal_cycle_counter(cycle_count)
    );

    // registers
    xts_ctrl_t ctrl;
    xts_ctrl_t next_ctrl;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] next_irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] next_irq_mask;
    logic [31:0] next_prdata;

    // sequencer state
    xts_seq_state_t state;
    xts_seq_state_t next_state;
    logic [TIMER_W-1:0] timer;
    logic [TIMER_W-1:0] next_timer;
    logic [TRIM_W-1:0] next_trim;
    logic next_settled;
    logic next_trim_applied;
    xts_trim_sel_t sel;
    logic delay_done;

    assign sel = xts_trim_sel_t'(ctrl.trim_select);
    assign delay_done = cycle_count >= xts_units64(ctrl.count_n);

    // trim sequencing
    always_comb begin
        next_state = state;
        next_timer = timer;
        next_en_prev = en_s;
        case (state)
            ST_OFF: begin
                next_timer = '0;
                if (en_rise) begin
                    next_state = (sel == SEL_STATIC) ? ST_FINAL : ST_START;
                end
            end
            ST_START: begin
                case (sel)
                    SEL_COUNTER: begin
                        if (delay_done) begin
                            next_state = ST_FINAL;
                        end
                    end
                    SEL_AMP_FILTER: begin
                        if (amp_s) begin
                            next_state = ST_FINAL;
                        end
                    end
                    SEL_STATIC: begin
                        next_state = ST_FINAL;
                    end
                    default: begin
                        if (timer == RAMP_TIMEOUT_LAST) begin
                            next_state = ST_RAMP;
                        end else begin
                            next_timer = timer + TIMER_W'(1);
                        end
                    end
                endcase
            end
            ST_RAMP: begin
                // a select change mid-sequence is honoured from this stage as well
                if (sel == SEL_STATIC) begin
                    next_state = ST_FINAL;
                end else if (sel == SEL_COUNTER) begin
                    if (delay_done) begin
                        next_state = ST_FINAL;
                    end
                end else if (amp_s) begin
                    next_state = ST_FINAL;
                end
            end
            default: begin
                next_state = ST_FINAL;
            end
        endcase
        if (!en_s) begin
            next_state = ST_OFF;
        end
    end

    // trim driven to the crystal follows the next state so it never lags a stage change
    always_comb begin
        case (next_state)
            ST_START: begin
                next_trim = trim_values.startup_trim_value;
            end
            ST_RAMP: begin
                next_trim = trim_values.ramp_trim_value;
            end
            default: begin
                // off and final both present the final value, so static mode never sees another
                next_trim = trim_values.final_trim_value;
            end
        endcase
        next_trim_applied = (next_trim == trim_values.final_trim_value);
        if (cnt_restart) begin
            next_settled = 1'b0;
        end else begin
            next_settled = crystal_settled | (cycle_count >= xts_units64(ctrl.settle_n));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_OFF;
            timer <= '0;
            en_prev <= 1'b0;
            xtal_trim <= '0;
            crystal_settled <= 1'b0;
            trim_applied <= 1'b1;
        end else begin
            state <= next_state;
            timer <= next_timer;
            en_prev <= next_en_prev;
            xtal_trim <= next_trim;
            crystal_settled <= next_settled;
            trim_applied <= next_trim_applied;
        end
    end

    // apb decode
    logic setup;
    logic access;
    logic wr;
    logic hit_stat;
    logic hit_ctrl;
    logic hit_irq_status;
    logic hit_irq_mask;
    logic hit_any;
    logic [IDX_DEC_W-1:0] word;
    logic [IRQ_W-1:0] events;
    xts_sys_status_t sys_status;

    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign word = paddr[IDX_DEC_W+1:2];
    assign hit_any = hit_stat | hit_ctrl | hit_irq_status | hit_irq_mask;
    // zero wait states; an unmapped word answers with an error
    assign pready = access;
    assign pslverr = access & ~hit_any;
    assign wr = access & pwrite;

    always_comb begin
        hit_stat = 1'b0;
        hit_ctrl = 1'b0;
        hit_irq_status = 1'b0;
        hit_irq_mask = 1'b0;
        if (word == SYS_STAT_IDX[IDX_DEC_W-1:0]) begin
            hit_stat = 1'b1;
        end else if (word == TRIM_CTRL_IDX[IDX_DEC_W-1:0]) begin
            hit_ctrl = 1'b1;
        end else if (word == IRQ_STATUS_IDX[IDX_DEC_W-1:0]) begin
            hit_irq_status = 1'b1;
        end else if (word == IRQ_MASK_IDX[IDX_DEC_W-1:0]) begin
            hit_irq_mask = 1'b1;
        end
    end

    always_comb begin
        sys_status.crystal_settled_flag = crystal_settled;
        sys_status.trim_applied_flag = trim_applied;
        sys_status.reserved = 1'b0;
        sys_status.debugger_attached_flag = dom_s.debugger_attached;
        sys_status.timer_domain_on_flag = dom_s.timer_power_domain_on;
        sys_status.timer_domain_off_flag = dom_s.timer_power_domain_off;
        sys_status.radio_domain_on_flag = dom_s.radio_power_domain_on;
        sys_status.radio_domain_off_flag = dom_s.radio_power_domain_off;
    end

    // register writes, sticky events and read data
    always_comb begin
        next_ctrl = ctrl;
        next_irq_mask = irq_mask;
        events = '0;
        events[IRQ_SETTLED_BIT] = next_settled & ~crystal_settled;
        events[IRQ_TRIM_BIT] = next_trim_applied & ~trim_applied;
        next_irq_status = irq_status;
        if (wr && hit_ctrl) begin
            next_ctrl = pwdata[13:0];
        end
        if (wr && hit_irq_mask) begin
            next_irq_mask = pwdata[IRQ_W-1:0];
        end
        if (wr && hit_irq_status) begin
            next_irq_status = irq_status & ~pwdata[IRQ_W-1:0];
        end
        // a new event in the clearing cycle stays set
        next_irq_status = next_irq_status | events;
        next_prdata = prdata;
        if (setup) begin
            next_prdata = '0;
            if (hit_stat) begin
                next_prdata[7:0] = sys_status;
            end else if (hit_ctrl) begin
                next_prdata[13:0] = ctrl;
            end else if (hit_irq_status) begin
                next_prdata[IRQ_W-1:0] = irq_status;
            end else if (hit_irq_mask) begin
                next_prdata[IRQ_W-1:0] = irq_mask;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
            irq_status <= IRQ_RESET;
            irq_mask <= IRQ_RESET;
            prdata <= '0;
        end else begin
            ctrl <= next_ctrl;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            prdata <= next_prdata;
        end
    end

    assign irq = |(irq_status & irq_mask);

endmodule : xts_trim_seq_status

// *** sim/xts_trim_seq_status_properties.sv ***
// concurrent checks on the ports of the crystal trim sequencer
module xts_trim_seq_status_properties
    import xts_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // crystal
    input wire logic xtal_enable,
    input wire logic xtal_tick_toggle,
    input wire xts_pkg::xts_trim_set_t trim_values,
    input wire logic [xts_pkg::TRIM_W-1:0] xtal_trim,
    // status
    input wire logic crystal_settled,
    input wire logic trim_applied,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr, tick_q;
    logic [13:0] ctrl, next_ctrl;
    logic [1:0] mask, next_mask;
    logic [12:0] ticks, next_ticks;
    logic [9:0] en_cyc, next_en_cyc;
    // shadows of the writable fields; pin-level tick count is never below the synchronised one while enabled
    always_comb begin
        wr = psel && penable && pwrite;
        next_ctrl = (wr && paddr[11:2] == TRIM_CTRL_IDX[9:0]) ? pwdata[13:0] : ctrl;
        next_mask = (wr && paddr[11:2] == IRQ_MASK_IDX[9:0]) ? pwdata[1:0] : mask;
        next_ticks = !xtal_enable ? 13'h0 : ticks + 13'(tick_q != xtal_tick_toggle);
        next_en_cyc = !xtal_enable ? 10'h0 : en_cyc + 10'(en_cyc != 10'h3ff);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
            mask <= 2'h0;
            ticks <= 13'h0;
            en_cyc <= 10'h0;
            tick_q <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            mask <= next_mask;
            ticks <= next_ticks;
            en_cyc <= next_en_cyc;
            tick_q <= xtal_tick_toggle;
        end
    end
    chk_apb_ready: assert property (psel && penable |-> pready)
        else $error("pready low in access cycle");
    chk_err_in_access: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access cycle");
    chk_trim_match: assert property (
        $past(presetn) && $stable(trim_values) |-> trim_applied == (xtal_trim == trim_values.final_trim_value))
        else $error("trim applied flag disagrees with driven trim");
    chk_settle_not_early: assert property (
        $rose(crystal_settled) |-> ticks >= {1'b0, ctrl[13:8], 6'h0})
        else $error("settled before threshold");
    chk_settled_sticky: assert property (
        xtal_enable [*4] ##0 crystal_settled |=> crystal_settled)
        else $error("settled dropped while enabled");
    chk_count_not_early: assert property (
        ctrl[7:6] == 2'h0 && xtal_enable && $past(xtal_enable) && $changed(xtal_trim)
            && xtal_trim == trim_values.final_trim_value |-> ticks >= {1'b0, ctrl[5:0], 6'h0})
        else $error("counter mode switched early");
    chk_static_final: assert property (
        ctrl[7:6] == 2'h2 && $past(ctrl[7:6]) == 2'h2 && $stable(trim_values) && $past(presetn)
            |-> xtal_trim == trim_values.final_trim_value)
        else $error("static mode not driving final trim");
    chk_ramp_not_early: assert property (
        ctrl[7:6] == 2'h3 && xtal_enable && xtal_trim == trim_values.ramp_trim_value
            && xtal_trim != trim_values.final_trim_value && xtal_trim != trim_values.startup_trim_value
            |-> en_cyc >= 10'h140)
        else $error("ramp trim before timeout");
    chk_ramp_in_time: assert property (
        ctrl[7:6] == 2'h3 && en_cyc == 10'h14a && trim_values.startup_trim_value != trim_values.ramp_trim_value
            |-> xtal_trim != trim_values.startup_trim_value)
        else $error("still startup trim after timeout");
    chk_irq_masked: assert property (mask == 2'h0 |-> !irq)
        else $error("irq with all sources masked");
    cov_settled: cover property ($rose(crystal_settled));
    cov_slverr: cover property (pslverr);
    cov_irq_clear: cover property (irq ##1 !irq);
endmodule : xts_trim_seq_status_properties

bind xts_trim_seq_status xts_trim_seq_status_properties u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .pslverr, .xtal_enable, .xtal_tick_toggle, .trim_values, .xtal_trim, .crystal_settled,
    .trim_applied, .irq);

// *** sim/xts_xtal_model.sv ***
// behavioural crystal: divided tick toggle and amplitude detector
module xts_xtal_model (
    // clock
    input wire logic pclk,
    // control
    input wire logic enable,
    input wire integer amp_delay,
    // crystal outputs
    output logic tick_toggle,
    output logic amp_ramping
);
    timeunit 1ns;
    timeprecision 1ns;
    logic div = 1'b0;
    int age = 0;
    initial begin
        tick_toggle = 1'b0;
        amp_ramping = 1'b0;
    end
    // tick stands still while stopped; amp_delay lets a test pick a slow or fast ramp
    always @(posedge pclk) begin
        if (!enable) begin
            div <= 1'b0;
            age <= 0;
            amp_ramping <= 1'b0;
        end else begin
            div <= !div;
            age <= age + 1;
            amp_ramping <= (age >= amp_delay);
            if (div)
                tick_toggle <= !tick_toggle;
        end
    end
endmodule : xts_xtal_model

// *** sim/xts_trim_seq_status_bench.sv ***
// self-checking bench for the crystal trim sequencer and status block
module xts_trim_seq_status_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import xts_pkg::*;
    localparam logic [31:0] A_STAT = SYS_STAT_IDX << 2;
    localparam logic [31:0] A_CTRL = TRIM_CTRL_IDX << 2;
    localparam logic [31:0] A_IRQ = IRQ_STATUS_IDX << 2;
    localparam logic [31:0] A_MASK = IRQ_MASK_IDX << 2;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic xtal_enable = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, xtal_tick_toggle, xtal_amp_ramping, crystal_settled, trim_applied, irq;
    logic [TRIM_W-1:0] xtal_trim;
    xts_trim_set_t trim_values = {8'h11, 8'h22, 8'h33};
    xts_dom_status_t dom_status = 5'h05;
    integer amp_delay = 50;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    int t0 = 0;

    xts_trim_seq_status u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .xtal_enable, .xtal_tick_toggle, .xtal_amp_ramping, .trim_values, .xtal_trim, .dom_status,
        .crystal_settled, .trim_applied, .irq);
    xts_xtal_model u_xtal (.pclk, .enable(xtal_enable), .amp_delay, .tick_toggle(xtal_tick_toggle),
        .amp_ramping(xtal_amp_ramping));

    initial begin
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles > 20000) begin
            failures++;
            tally_and_finish();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    // one transfer; the request is held until pready is seen at a rising edge, only the global timeout ends a hang
    task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [31:0] addr, input logic [31:0] exp, input string what);
        apb(1'b0, addr, 32'h0);
        check(what, exp, rd);
    endtask : rdchk

    task automatic go(input logic [13:0] ctrl);
        apb(1'b1, A_CTRL, {18'h0, ctrl});
        @(posedge pclk);
        xtal_enable <= 1'b1;
        #1;
        t0 = cycles;
    endtask : go

    task automatic stop();
        @(posedge pclk);
        xtal_enable <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask : stop

    // waits for a trim value, or for settled, and judges the cycles since enable
    task automatic wait_for(input bit on_settled, input logic [7:0] v, input int lo, input int hi, input string what);
        while ((on_settled ? crystal_settled !== 1'b1 : xtal_trim !== v) && cycles - t0 < 2000) begin
            @(posedge pclk);
            #1;
        end
        check(what, 32'h1, cycles - t0 >= lo && cycles - t0 <= hi);
    endtask : wait_for

    task automatic t_reset();
        rdchk(A_CTRL, 32'h3f22, "control reset");
        rdchk(A_STAT, 32'h45, "status reset");
        apb(1'b1, A_STAT, 32'hff);
        rdchk(A_STAT, 32'h45, "status read only");
        rdchk(32'h100, 32'h0, "unmapped data");
        check("unmapped error", 32'h1, err);
        $display("test reset done");
    endtask : t_reset

    task automatic t_domains();
        xts_dom_status_t vals [2] = '{5'h1a, 5'h05};
        foreach (vals[i]) begin
            dom_status <= vals[i];
            repeat (3) @(posedge pclk);
            rdchk(A_STAT, {24'h0, 3'h2, vals[i]}, "domain status");
        end
        $display("test domains done");
    endtask : t_domains

    task automatic t_counter();
        apb(1'b1, A_MASK, 32'h3);
        go(14'h0201);
        wait_for(0, 8'h11, 1, 6, "startup trim");
        check("applied in startup", 32'h0, trim_applied);
        wait_for(0, 8'h33, 128, 140, "counter switch");
        check("applied at final", 32'h1, trim_applied);
        wait_for(1, 8'h0, 256, 270, "settle time");
        rdchk(A_STAT, 32'hc5, "status settled");
        rdchk(A_IRQ, 32'h3, "irq status");
        check("irq raised", 32'h1, irq);
        apb(1'b1, A_IRQ, 32'h3);
        rdchk(A_IRQ, 32'h0, "irq cleared");
        check("irq low", 32'h0, irq);
        apb(1'b1, A_MASK, 32'h1);
        stop();
        check("settled cleared", 32'h0, crystal_settled);
        go(14'h0201);
        wait_for(0, 8'h11, 1, 6, "restart trim");
        wait_for(1, 8'h0, 256, 270, "restart settle");
        rdchk(A_IRQ, 32'h3, "irq both");
        apb(1'b1, A_IRQ, 32'h1);
        #1;
        check("irq masked", 32'h0, irq);
        stop();
        $display("test counter mode done");
    endtask : t_counter

    task automatic t_amp();
        go(14'h0241);
        wait_for(0, 8'h11, 1, 6, "amp startup");
        wait_for(0, 8'h33, 50, 62, "amp switch");
        stop();
        $display("test amplitude mode done");
    endtask : t_amp

    task automatic t_static();
        go(14'h0281);
        repeat (6) begin
            @(posedge pclk);
            #1;
            check("static trim", 32'h33, xtal_trim);
        end
        @(posedge pclk);
        trim_values.final_trim_value <= 8'h44;
        repeat (2) @(posedge pclk);
        #1;
        check("static follows", 32'h44, xtal_trim);
        check("static applied", 32'h1, trim_applied);
        stop();
        trim_values.final_trim_value <= 8'h33;
        $display("test static mode done");
    endtask : t_static

    task automatic t_two();
        amp_delay <= 500;
        go(14'h02c1);
        wait_for(0, 8'h11, 1, 6, "two stage startup");
        wait_for(0, 8'h22, 320, 330, "ramp after timeout");
        wait_for(0, 8'h33, 500, 512, "final on ramping");
        check("two stage applied", 32'h1, trim_applied);
        stop();
        $display("test two stage done");
    endtask : t_two

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_domains();
        t_counter();
        t_amp();
        t_static();
        t_two();
        tally_and_finish();
    end
endmodule : xts_trim_seq_status_bench
